// >>> asc_cfg_if.sv
// interface carrying the line configuration from the top to both shifters
// assumes: config is static while a character is on the line
`timescale 1ns/1ps
interface asc_cfg_if;
  logic [1:0]        char_len_m5;   // length minus five
  logic              parity_on;
  logic              parity_odd;
  logic              wake_on;
  logic [1:0]        stop_two;      // bit0: two stop bits
  asc_pkg::asc_rate_e rate;
  modport src (output char_len_m5, parity_on, parity_odd, wake_on, stop_two, rate);
  modport dst (input  char_len_m5, parity_on, parity_odd, wake_on, stop_two, rate);
endinterface : asc_cfg_if

// >>> asc_partner.sv
// partner: supplies both bit clocks, drives receive data, captures transmit frames
// assumes: clk paces it; receive traffic uses the undivided clock
`timescale 1ns/1ps
module asc_partner (
  // pacing
  input  wire logic clk,
  input  wire logic txc_on,
  // port pins
  output logic      rxc,
  output logic      rxd,
  output logic      txc,
  input  wire logic txd
);
  localparam int HALF = 8; // half bit clock, in system clocks
  // ------------------------------------------------------------
  // clocks and line
  // ------------------------------------------------------------
  // pins idle: clocks parked low, receive line marking
  initial begin
    rxc = 1'b0;
    rxd = 1'b1;
    txc = 1'b0;
  end
  // transmit clock parks low only, so no stray fall moves the line
  always begin
    repeat (HALF) @(negedge clk);
    if (txc_on || txc) txc = ~txc;
  end
  // data set while clock low, so rises see settled bits
  task automatic send(input logic [11:0] bits, input int n);
    for (int i = 0; i < n; i++) begin
      rxd = bits[i];
      repeat (HALF) @(negedge clk);
      rxc = 1'b1;
      repeat (HALF) @(negedge clk);
      rxc = 1'b0;
    end
    rxd = 1'b1;
  endtask : send
  // sample on rises, div rises apart; bits not seen stay high
  task automatic get(input int n, input int div, output logic [11:0] bits);
    int w;
    w = 0;
    bits = 12'hFFF;
    @(posedge txc);
    while (txd !== 1'b0 && w < 400) begin
      @(posedge txc);
      w++;
    end
    bits[0] = txd;
    for (int i = 1; i < n; i++) begin
      repeat (div) @(posedge txc);
      bits[i] = txd;
    end
  endtask : get
endmodule : asc_partner

// >>> asc_pkg.sv
// package for the asynchronous serial channel: register map, field layout, resets
// assumes: one system clock; the partner drives both bit clocks on port pins
package asc_pkg;
  // -----------------------------------------------------------------
  // register addresses
  // -----------------------------------------------------------------
  localparam logic [7:0] SERIAL_RECEIVE_CONTROL_ADDR = 8'h00_EC;
  localparam logic [7:0] SERIAL_DATA_ADDR            = 8'h00_EF;

  // -----------------------------------------------------------------
  // receive control field positions
  // -----------------------------------------------------------------
  localparam int RC_ENABLE_BIT  = 0;
  localparam int RC_CTRL_BIT    = 1;
  localparam int RC_AVAIL_BIT   = 2;
  localparam int RC_OVERRUN_BIT = 3;
  localparam int RC_FRAMING_BIT = 4;
  localparam int RC_PARITY_BIT  = 5;
  localparam int RC_WAKE_BIT    = 6;

  // -----------------------------------------------------------------
  // reset values and counts
  // -----------------------------------------------------------------
  localparam logic [7:0] RC_RESET      = 8'h00_00;
  localparam logic [7:0] DATA_RESET    = 8'h00_FF;
  localparam logic [7:0] CTRL_CHAR_MAX = 8'h00_1F;
  localparam logic [7:0] CTRL_CHAR_DEL = 8'h00_7F;
  localparam int         MIN_CHAR_BITS = 5;
  localparam int         MAX_CHAR_BITS = 8;

  // clock divide selection
  typedef enum logic [1:0] {ASC_DIV1, ASC_DIV16, ASC_DIV32, ASC_DIV64} asc_rate_e;
endpackage : asc_pkg

// >>> asc_rx.sv
// receive shifter: start qualification, mid-bit sampling, character assembly
// assumes: rxc_rise is a one-cycle pulse, rxd already synchronised
`timescale 1ns/1ps
module asc_rx (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // configuration
  asc_cfg_if.dst           cfg,
  input  wire logic        enable,
  // line
  input  wire logic        rxc_rise,
  input  wire logic        rxd,
  // result
  output logic             done,
  output logic [7:0]       char_out,
  output logic             par_err,
  output logic             frm_err,
  output logic             wake_bit
);
  // -----------------------------------------------------------------
  // receive state machine
  // -----------------------------------------------------------------
  typedef enum {ASC_IDLE, ASC_START, ASC_BITS} asc_rx_state_e;
  asc_rx_state_e st, next_st;
  logic [5:0]  cnt, next_cnt;
  logic [3:0]  idx, next_idx;
  logic [10:0] sh, next_sh;
  logic        next_done;
  logic [5:0]  div_max;
  logic [3:0]  nbits;
  logic [3:0]  dlen;
  logic [7:0]  assembled;

  always_comb begin
    unique case (cfg.rate)
      asc_pkg::ASC_DIV1:  div_max = 6'd0;
      asc_pkg::ASC_DIV16: div_max = 6'd15;
      asc_pkg::ASC_DIV32: div_max = 6'd31;
      asc_pkg::ASC_DIV64: div_max = 6'd63;
    endcase
    dlen  = 4'd5 + 4'(cfg.char_len_m5);
    nbits = dlen + 4'(cfg.parity_on) + 4'(cfg.wake_on) + 4'd1; // data, parity, wake, stop
    // unused upper bits read as one, parity kept in the byte when there are fewer than eight data bits
    assembled = 8'h00_FF;
    for (int i = 0; i < 8; i++) begin
      if (i < 32'(dlen) + 32'(cfg.parity_on)) assembled[i] = sh[i];
    end
  end

  // sampling happens on rising receive clock edges only
  always_comb begin
    next_st   = st;
    next_cnt  = cnt;
    next_idx  = idx;
    next_sh   = sh;
    next_done = 1'b0;
    unique case (st)
      ASC_IDLE: begin
        if (enable && !rxd && rxc_rise) begin
          next_st  = (div_max == 6'd0) ? ASC_BITS : ASC_START;
          next_cnt = {1'b0, div_max[5:1]};
          next_idx = 4'd0;
          if (div_max == 6'd0) next_cnt = 6'd0;
        end
      end
      ASC_START: if (rxc_rise) begin
        if (rxd) begin
          next_st = ASC_IDLE;                               // glitch shorter than half a bit
        end else if (cnt == 6'd0) begin
          next_st  = ASC_BITS;
          next_cnt = div_max;
        end else begin
          next_cnt = cnt - 6'd1;
        end
      end
      ASC_BITS: if (rxc_rise) begin
        if (cnt == 6'd0) begin                              // mid-bit sample
          next_sh[idx] = rxd;
          next_idx     = idx + 4'd1;
          next_cnt     = div_max;
          if (idx + 4'd1 == nbits) begin
            next_st   = ASC_IDLE;
            next_done = 1'b1;
          end
        end else begin
          next_cnt = cnt - 6'd1;
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st   <= ASC_IDLE;
      cnt  <= 6'd0;
      idx  <= 4'd0;
      sh   <= '0;
      done <= 1'b0;
    end else begin
      st   <= next_st;
      cnt  <= next_cnt;
      idx  <= next_idx;
      sh   <= next_sh;
      done <= next_done;
    end
  end

  // result decode, valid with done
  always_comb begin
    char_out = assembled;
    par_err  = cfg.parity_on
             && ((^(sh[7:0] & (8'h00_FF >> (2'd3 - cfg.char_len_m5)))) ^ cfg.parity_odd) != sh[dlen];
    wake_bit = cfg.wake_on && sh[dlen + 4'(cfg.parity_on)];
    frm_err  = !sh[nbits - 4'd1];
  end
endmodule : asc_rx

// >>> asc_top.sv
// async serial channel: one data address for both directions, one receive control
// register, and transmit/receive shifters driven by partner-supplied bit clocks.
// assumes: register port is a simple synchronous read/write strobe pair on clk
`timescale 1ns/1ps
module asc_top (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // register port
  input  wire logic [7:0] reg_addr,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  // line configuration (held outside this block)
  input  wire logic [1:0] cfg_char_len_m5,
  input  wire logic       cfg_parity_on,
  input  wire logic       cfg_parity_odd,
  input  wire logic       cfg_wake_on,
  input  wire logic       cfg_two_stop,
  input  wire logic [1:0] cfg_rate,
  input  wire logic       cfg_break,
  input  wire logic [7:0] cfg_wake_match,
  // port pins
  input  wire logic       p2_0_rx_clk,
  input  wire logic       p3_0_rx_data,
  input  wire logic       p2_1_tx_clk,
  output logic            p3_1_tx_data,
  // status
  output logic            tx_busy,
  output logic            rx_wake
);
  // -----------------------------------------------------------------
  // reset release
  // -----------------------------------------------------------------
  logic [1:0] rst_sync;
  logic       srst_n;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) rst_sync <= 2'b00;
    else        rst_sync <= {rst_sync[0], 1'b1};
  end
  assign srst_n = rst_sync[1];

  // -----------------------------------------------------------------
  // pin synchronisers: three stages, change counts when 2nd and 3rd agree
  // -----------------------------------------------------------------
  logic [2:0] s_rxc, s_rxd, s_txc;
  logic       rxc_lvl, next_rxc_lvl, rxd_lvl, next_rxd_lvl, txc_lvl, next_txc_lvl;
  logic       rxc_rise, txc_fall;

  always_ff @(posedge clk or negedge srst_n) begin
    if (!srst_n) begin
      s_rxc <= 3'b000;
      s_rxd <= 3'b111;
      s_txc <= 3'b000;
    end else begin
      s_rxc <= {s_rxc[1:0], p2_0_rx_clk};
      s_rxd <= {s_rxd[1:0], p3_0_rx_data};
      s_txc <= {s_txc[1:0], p2_1_tx_clk};
    end
  end

  // filtered levels only move when stages two and three agree
  always_comb begin
    next_rxc_lvl = (s_rxc[1] == s_rxc[2]) ? s_rxc[2] : rxc_lvl;
    next_rxd_lvl = (s_rxd[1] == s_rxd[2]) ? s_rxd[2] : rxd_lvl;
    next_txc_lvl = (s_txc[1] == s_txc[2]) ? s_txc[2] : txc_lvl;
  end

  always_ff @(posedge clk or negedge srst_n) begin
    if (!srst_n) begin
      rxc_lvl <= 1'b0;
      rxd_lvl <= 1'b1;
      txc_lvl <= 1'b0;
    end else begin
      rxc_lvl <= next_rxc_lvl;
      rxd_lvl <= next_rxd_lvl;
      txc_lvl <= next_txc_lvl;
    end
  end

  assign rxc_rise = next_rxc_lvl & ~rxc_lvl;
  assign txc_fall = ~next_txc_lvl & txc_lvl;

  // -----------------------------------------------------------------
  // configuration carrier
  // -----------------------------------------------------------------
  asc_cfg_if cfg ();
  assign cfg.char_len_m5 = cfg_char_len_m5;
  assign cfg.parity_on   = cfg_parity_on;
  assign cfg.parity_odd  = cfg_parity_odd;
  assign cfg.wake_on     = cfg_wake_on;
  assign cfg.stop_two    = {1'b0, cfg_two_stop};
  assign cfg.rate        = asc_pkg::asc_rate_e'(cfg_rate);

  // -----------------------------------------------------------------
  // register decode
  // -----------------------------------------------------------------
  logic wr_data, rd_data, wr_ctrl;
  assign wr_data = reg_wr && reg_addr == asc_pkg::SERIAL_DATA_ADDR;
  assign rd_data = reg_rd && reg_addr == asc_pkg::SERIAL_DATA_ADDR;
  assign wr_ctrl = reg_wr && reg_addr == asc_pkg::SERIAL_RECEIVE_CONTROL_ADDR;

  // -----------------------------------------------------------------
  // transmit holding register: write waits here until the shifter is free
  // -----------------------------------------------------------------
  logic [7:0] tx_hold, next_tx_hold;
  logic       tx_full, next_tx_full;
  logic       tx_load, tx_shift_busy, tx_line;

  assign tx_load = tx_full && !tx_shift_busy;

  always_comb begin
    next_tx_hold = tx_hold;
    next_tx_full = tx_full;
    if (tx_load) next_tx_full = 1'b0;
    if (wr_data) begin                                     // a write while full replaces the byte
      next_tx_hold = reg_wdata;
      next_tx_full = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge srst_n) begin
    if (!srst_n) begin
      tx_hold <= 8'h00_00;
      tx_full <= 1'b0;
    end else begin
      tx_hold <= next_tx_hold;
      tx_full <= next_tx_full;
    end
  end

  asc_tx u_tx (
    .clk      (clk),
    .rst_n    (srst_n),
    .cfg      (cfg.dst),
    .load     (tx_load),
    .data     (tx_hold),
    .brk      (cfg_break),
    .txc_fall (txc_fall),
    .txd      (tx_line),
    .busy     (tx_shift_busy)
  );

  // -----------------------------------------------------------------
  // receive shifter
  // -----------------------------------------------------------------
  logic       rc_enable;
  logic       rx_done, rx_perr, rx_ferr, rx_wbit;
  logic [7:0] rx_char;

  asc_rx u_rx (
    .clk      (clk),
    .rst_n    (srst_n),
    .cfg      (cfg.dst),
    .enable   (rc_enable),
    .rxc_rise (rxc_rise),
    .rxd      (rxd_lvl),
    .done     (rx_done),
    .char_out (rx_char),
    .par_err  (rx_perr),
    .frm_err  (rx_ferr),
    .wake_bit (rx_wbit)
  );

  // -----------------------------------------------------------------
  // receive data register and control/status flags
  // the shifter keeps working while this byte waits to be read
  // -----------------------------------------------------------------
  logic [7:0] rx_data, next_rx_data;
  logic       avail, next_avail;
  logic       f_ctrl, next_f_ctrl;
  logic       f_ovr, next_f_ovr;
  logic       f_frm, next_f_frm;
  logic       f_par, next_f_par;
  logic       f_wake, next_f_wake;
  logic       next_rc_enable;
  logic       is_ctrl, wake_hit;

  assign is_ctrl  = (rx_char <= asc_pkg::CTRL_CHAR_MAX) || (rx_char == asc_pkg::CTRL_CHAR_DEL);
  // wake-up: a character with the wake bit set, or matching the programmed value
  assign wake_hit = cfg_wake_on && (rx_wbit || rx_char == cfg_wake_match);

  // software clears sticky flags by writing one; a same-cycle event wins
  always_comb begin
    next_rx_data   = rx_data;
    next_avail     = avail;
    next_f_ctrl    = f_ctrl;
    next_f_ovr     = f_ovr;
    next_f_frm     = f_frm;
    next_f_par     = f_par;
    next_f_wake    = f_wake;
    next_rc_enable = rc_enable;
    if (wr_ctrl) begin
      next_rc_enable = reg_wdata[asc_pkg::RC_ENABLE_BIT];
      if (reg_wdata[asc_pkg::RC_CTRL_BIT])    next_f_ctrl = 1'b0;
      if (reg_wdata[asc_pkg::RC_OVERRUN_BIT]) next_f_ovr  = 1'b0;
      if (reg_wdata[asc_pkg::RC_FRAMING_BIT]) next_f_frm  = 1'b0;
      if (reg_wdata[asc_pkg::RC_PARITY_BIT])  next_f_par  = 1'b0;
      if (reg_wdata[asc_pkg::RC_WAKE_BIT])    next_f_wake = 1'b0;
    end
    if (rd_data) next_avail = 1'b0;
    if (rx_done) begin
      next_rx_data = rx_char;
      next_avail   = 1'b1;
      next_f_ctrl  = is_ctrl;
      if (avail && !rd_data) next_f_ovr  = 1'b1;
      if (rx_ferr)           next_f_frm  = 1'b1;
      if (rx_perr)           next_f_par  = 1'b1;
      if (wake_hit)          next_f_wake = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge srst_n) begin
    if (!srst_n) begin
      rx_data   <= asc_pkg::DATA_RESET;
      avail     <= 1'b0;
      f_ctrl    <= 1'b0;
      f_ovr     <= 1'b0;
      f_frm     <= 1'b0;
      f_par     <= 1'b0;
      f_wake    <= 1'b0;
      rc_enable <= 1'b0;
    end else begin
      rx_data   <= next_rx_data;
      avail     <= next_avail;
      f_ctrl    <= next_f_ctrl;
      f_ovr     <= next_f_ovr;
      f_frm     <= next_f_frm;
      f_par     <= next_f_par;
      f_wake    <= next_f_wake;
      rc_enable <= next_rc_enable;
    end
  end

  // -----------------------------------------------------------------
  // read data and registered outputs
  // -----------------------------------------------------------------
  logic [7:0] rc_view, next_rdata;

  always_comb begin
    rc_view = 8'h00_00;
    rc_view[asc_pkg::RC_ENABLE_BIT]  = rc_enable;
    rc_view[asc_pkg::RC_CTRL_BIT]    = f_ctrl;
    rc_view[asc_pkg::RC_AVAIL_BIT]   = avail;
    rc_view[asc_pkg::RC_OVERRUN_BIT] = f_ovr;
    rc_view[asc_pkg::RC_FRAMING_BIT] = f_frm;
    rc_view[asc_pkg::RC_PARITY_BIT]  = f_par;
    rc_view[asc_pkg::RC_WAKE_BIT]    = f_wake;
    next_rdata = reg_rdata;
    if (rd_data) next_rdata = rx_data;
    else if (reg_rd && reg_addr == asc_pkg::SERIAL_RECEIVE_CONTROL_ADDR) next_rdata = rc_view;
    else if (reg_rd) next_rdata = 8'h00_00;
  end

  always_ff @(posedge clk or negedge srst_n) begin
    if (!srst_n) begin
      reg_rdata    <= 8'h00_00;
      p3_1_tx_data <= 1'b1;
      tx_busy      <= 1'b0;
      rx_wake      <= 1'b0;
    end else begin
      reg_rdata    <= next_rdata;
      p3_1_tx_data <= tx_line;
      tx_busy      <= tx_full | tx_shift_busy;
      rx_wake      <= f_wake;
    end
  end
endmodule : asc_top

// >>> asc_top_properties.sv
// checker: timing relations seen at the serial channel top ports
// assumes: bound onto asc_top; one clock, clk, and rst_n
`timescale 1ns/1ps
module asc_top_properties (
  // clock and reset
  input wire logic       clk,
  input wire logic       rst_n,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  // line and status
  input wire logic       cfg_break,
  input wire logic [1:0] cfg_rate,
  input wire logic       p2_1_tx_clk,
  input wire logic       p3_1_tx_data,
  input wire logic       tx_busy
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ------------------------------------------------------------
  // sequences and properties
  // ------------------------------------------------------------
  // break must have stood over a full bit clock plus sync
  sequence s_load;
    reg_wr && reg_addr == asc_pkg::SERIAL_DATA_ADDR;
  endsequence
  sequence s_brk;
    cfg_break && $past(cfg_break, 8) && $past(cfg_break, 16) && $past(cfg_break, 24);
  endsequence
  property p_idle_high;
    !tx_busy && !cfg_break && !$past(cfg_break, 8) && !$past(cfg_break, 16) && !$past(cfg_break, 24) |-> p3_1_tx_data;
  endproperty
  a_idle_high: assert property (p_idle_high) else $error("tx line low while idle");
  property p_tx_fall;
    $changed(p3_1_tx_data) |-> !p2_1_tx_clk && !$past(p2_1_tx_clk, 2);
  endproperty
  a_tx_fall: assert property (p_tx_fall) else $error("tx line moved outside a clock fall");
  property p_break;
    s_brk |-> !p3_1_tx_data;
  endproperty
  a_break: assert property (p_break) else $error("tx line high during break");
  property p_busy;
    s_load |-> ##[1:2] tx_busy;
  endproperty
  a_busy: assert property (p_busy) else $error("write did not start transmit");
  property p_start;
    s_load ##0 (cfg_rate == 2'b00 && !cfg_break) |-> ##[1:48] !p3_1_tx_data;
  endproperty
  a_start: assert property (p_start) else $error("no start bit after write");
  property p_end_high;
    $fell(tx_busy) && !cfg_break |-> p3_1_tx_data;
  endproperty
  a_end_high: assert property (p_end_high) else $error("tx line low at end of frame");
  property p_unmapped;
    reg_rd && reg_addr != asc_pkg::SERIAL_DATA_ADDR && reg_addr != asc_pkg::SERIAL_RECEIVE_CONTROL_ADDR
      |=> reg_rdata == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_rd_hold;
    !$past(reg_rd) |-> $stable(reg_rdata);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved without a read");
endmodule : asc_top_properties

bind asc_top asc_top_properties asc_top_properties_inst (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cfg_break(cfg_break), .cfg_rate(cfg_rate),
  .p2_1_tx_clk(p2_1_tx_clk), .p3_1_tx_data(p3_1_tx_data), .tx_busy(tx_busy));

// >>> asc_top_tb.sv
// testbench: register reads and writes plus framed traffic against the partner
// assumes: asc_pkg, asc_top and asc_partner are compiled first
`timescale 1ns/1ps
module asc_top_tb;
  logic        clk, rst_n, wr, rd, par, odd, brk, txc_on, rxc, rxd, txc, txd, busy, wake, wk;
  logic [1:0]  len, rate;
  logic [7:0]  addr, wdata, rdata, v;
  logic [11:0] got;
  int          errors, checks;
  localparam logic [7:0] RC = asc_pkg::SERIAL_RECEIVE_CONTROL_ADDR;
  localparam logic [7:0] DA = asc_pkg::SERIAL_DATA_ADDR;
  always #50 clk = ~clk;
  asc_top asc_top_inst (.clk(clk), .rst_n(rst_n), .reg_addr(addr), .reg_wr(wr), .reg_rd(rd), .reg_wdata(wdata),
    .reg_rdata(rdata), .cfg_char_len_m5(len), .cfg_parity_on(par), .cfg_parity_odd(odd), .cfg_wake_on(wk),
    .cfg_two_stop(1'b0), .cfg_rate(rate), .cfg_break(brk), .cfg_wake_match(8'h00), .p2_0_rx_clk(rxc),
    .p3_0_rx_data(rxd), .p2_1_tx_clk(txc), .p3_1_tx_data(txd), .tx_busy(busy), .rx_wake(wake));
  asc_partner asc_partner_inst (.clk(clk), .txc_on(txc_on), .rxc(rxc), .rxd(rxd), .txc(txc), .txd(txd));
  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic finish_test;
    if (errors == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : finish_test
  task automatic chk(input logic [11:0] g, input logic [11:0] e);
    checks++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a);
    @(negedge clk);
    addr = a;
    rd = 1'b1;
    @(negedge clk);
    rd = 0;
    v = rdata;
  endtask : rd_reg
  // start, data lsb first, parity, then stop and padding ones
  function automatic logic [11:0] frame(input logic [7:0] d, input int n, input logic p, input logic o);
    logic [11:0] f;
    f = 12'hFFE;
    for (int i = 0; i < n; i++) f[i+1] = d[i];
    if (p) f[n+1] = ^(d & (8'hFF >> (8 - n))) ^ o;
    return f;
  endfunction : frame
  task automatic tx_case(input logic [7:0] d, input int l, input logic p, input logic o, input int r);
    len = 2'(l - 5);
    par = p;
    odd = o;
    rate = 2'(r);
    wr_reg(DA, d);
    asc_partner_inst.get(l + 2 + p, 1 << (r == 0 ? 0 : r + 3), got);
    chk(got, frame(d, l, p, o));
    for (int i = 0; i < 3000 && busy !== 1'b0; i++) @(negedge clk);
  endtask : tx_case
  // bad bit 0 flips parity, bad bit 1 drops the stop bit
  task automatic rx_send(input logic [7:0] d, input int l, input logic p, input logic o, input logic [1:0] bad);
    logic [11:0] f;
    f = frame(d, l, p, o);
    len = 2'(l - 5);
    par = p;
    odd = o;
    rate = 2'b00;
    if (bad[0]) f[l+1] = ~f[l+1];
    if (bad[1]) f[l+1+p] = 1'b0;
    asc_partner_inst.send(f, l + 2 + p);
    repeat (4) @(negedge clk);
  endtask : rx_send
  task automatic rx_case(input logic [7:0] d, input int l, input logic p, input logic o, input logic [1:0] bad,
                         input logic [7:0] fl);
    logic [11:0] f;
    f = frame(d, l, p, o);
    rx_send(d, l, p, o, bad);
    rd_reg(RC);
    chk(v, 8'h05 | fl);
    rd_reg(DA);
    chk(v, f[8:1]);
    wr_reg(RC, 8'h7B);
  endtask : rx_case
  // ------------------------------------------------------------
  // sequence and watchdog
  // ------------------------------------------------------------
  initial begin
    #6_000_000;
    errors++;
    finish_test();
  end
  initial begin
    {clk, rst_n, wr, rd, par, odd, brk, txc_on, wk, errors, checks} = '0;
    {addr, wdata, len, rate} = '0;
    repeat (5) @(negedge clk);
    rst_n = 1'b1;
    repeat (3) @(negedge clk);
    rd_reg(RC);
    chk(v, asc_pkg::RC_RESET);
    rd_reg(8'hED);
    chk(v, 8'h00);
    chk(txd, 1'b1);
    txc_on = 1'b1;
    tx_case(8'hE5, 5, 1'b1, 1'b0, 0);
    tx_case(8'h6C, 7, 1'b1, 1'b1, 0);
    for (int r = 0; r < 4; r++) tx_case(8'hA3, 8, 1'b0, 1'b0, r);
    brk = 1'b1;
    repeat (40) @(negedge clk);
    chk(txd, 1'b0);
    brk = 1'b0;
    repeat (40) @(negedge clk);
    chk(txd, 1'b1);
    txc_on = 1'b0;
    rx_send(8'h41, 8, 1'b0, 1'b0, 2'b00);
    rd_reg(RC);
    chk(v, 8'h00);
    wr_reg(RC, 8'h01);
    rx_case(8'h07, 7, 1'b1, 1'b0, 2'b00, 8'h00);
    rx_case(8'h0A, 5, 1'b0, 1'b0, 2'b00, 8'h00);
    rx_case(8'h0D, 8, 1'b0, 1'b0, 2'b00, 8'h02);
    rx_case(8'h55, 8, 1'b1, 1'b1, 2'b01, 8'h20);
    rx_case(8'h33, 8, 1'b0, 1'b0, 2'b10, 8'h10);
    rx_send(8'h31, 8, 1'b0, 1'b0, 2'b00);
    rx_case(8'h32, 8, 1'b0, 1'b0, 2'b00, 8'h08);
    // wake on: eight data bits, then a one in the wake slot, then the stop bit
    wk = 1'b1;
    asc_partner_inst.send(frame(8'h5A, 8, 1'b0, 1'b0), 11);
    repeat (4) @(negedge clk);
    chk(wake, 1'b1);
    rd_reg(RC);
    chk(v, 8'h45);
    rd_reg(DA);
    wr_reg(RC, 8'h7B);
    wk = 1'b0;
    @(negedge clk);
    chk(wake, 1'b0);
    rd_reg(RC);
    chk(v, 8'h01);
    finish_test();
  end
endmodule : asc_top_tb

// >>> asc_tx.sv
// transmit shifter: frames a held byte and shifts on falling transmit clock edges
// assumes: txc_fall is a one-cycle pulse from synchronised pin logic
`timescale 1ns/1ps
module asc_tx (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // configuration
  asc_cfg_if.dst           cfg,
  // request
  input  wire logic        load,
  input  wire logic [7:0]  data,
  input  wire logic        brk,
  input  wire logic        txc_fall,
  // line and status
  output logic             txd,
  output logic             busy
);
  // -----------------------------------------------------------------
  // frame shifter
  // -----------------------------------------------------------------
  logic [12:0] shreg, next_shreg;
  logic [3:0]  left, next_left;
  logic [5:0]  pre, next_pre;
  logic        next_txd;
  logic [5:0]  div_max;
  logic [7:0]  masked;
  logic        par;
  logic [3:0]  nbits;

  // divider top, parity and frame length
  always_comb begin
    unique case (cfg.rate)
      asc_pkg::ASC_DIV1:  div_max = 6'd0;
      asc_pkg::ASC_DIV16: div_max = 6'd15;
      asc_pkg::ASC_DIV32: div_max = 6'd31;
      asc_pkg::ASC_DIV64: div_max = 6'd63;
    endcase
    masked = data & (8'h00_FF >> (2'd3 - cfg.char_len_m5));
    par    = ^masked ^ cfg.parity_odd;
    nbits  = 4'd1 + 4'(cfg.char_len_m5) + 4'd5 + 4'(cfg.parity_on) + 4'(cfg.wake_on)
           + 4'd1 + 4'(cfg.stop_two[0]);
  end

  // load builds the frame lsb first: start, data, parity, wake, stops
  always_comb begin
    next_shreg = shreg;
    next_left  = left;
    next_pre   = pre;
    next_txd   = txd;
    if (load && left == 4'd0) begin
      next_shreg = '1;
      next_shreg[0] = 1'b0;
      for (int i = 0; i < 8; i++) begin
        if (i < 32'(cfg.char_len_m5) + 5) next_shreg[i+1] = masked[i];
      end
      if (cfg.parity_on) next_shreg[4'd6 + 4'(cfg.char_len_m5)] = par;
      if (cfg.wake_on)
        next_shreg[4'd6 + 4'(cfg.char_len_m5) + 4'(cfg.parity_on)] = 1'b1;
      next_left = nbits;
      next_pre  = 6'd0;
    end else if (txc_fall) begin
      if (left != 4'd0) begin
        if (pre == 6'd0) begin
          next_txd   = shreg[0];
          next_shreg = {1'b1, shreg[12:1]};
          next_left  = left - 4'd1;
          next_pre   = div_max;
        end else begin
          next_pre = pre - 6'd1;
        end
      end else begin
        next_txd = 1'b1;
      end
      if (brk) next_txd = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      shreg <= '1;
      left  <= 4'd0;
      pre   <= 6'd0;
      txd   <= 1'b1;
    end else begin
      shreg <= next_shreg;
      left  <= next_left;
      pre   <= next_pre;
      txd   <= next_txd;
    end
  end

  assign busy = (left != 4'd0);
endmodule : asc_tx
